// ### verilog/ieee488_remote_command_port.sv
// Remote command parser, bus interface functions and status for the remote port
`include "rcp_consts.svh"
module ieee488_remote_command_port
  import rcp_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic [4:0] cfg_addr,
  input  wire logic       ansi_mode,
  input  wire logic [7:0] home_row_bcd,
  input  wire logic [7:0] home_col_bcd,
  input  wire logic       bus_addr_stb,
  input  wire logic [4:0] bus_addr,
  input  wire bus_evt_t   bus_evt,
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_byte,
  output logic            rx_ready,
  input  wire logic       panel_valid,
  input  wire key_t       panel_key,
  input  wire logic       prog_wait_trig,
  input  wire err_t       instr_err,
  input  wire logic       attr_req,
  input  wire attr_op_t   attr_op,
  output logic            attr_ready,
  input  wire logic       tx_ready,
  output logic            tx_valid,
  output logic      [7:0] tx_byte,
  output logic            key_valid,
  output key_t            key_out,
  output logic            addr_ok,
  output logic            listening,
  output logic            remote,
  output logic            lockout,
  output logic      [7:0] status_byte,
  output logic            srq,
  output logic            dev_clear,
  output logic            trig_resume
);
  top_st_t    s_r;
  top_st_t    s_nxt;
  err_t       err_all;
  logic       take;
  logic [7:0] c;

  // Folds lower-case letters onto upper case
  function automatic logic [7:0] upcase(input logic [7:0] b);
    upcase = (b >= `CH_LC_A && b <= `CH_LC_Z) ? b - `CH_CASE_OFS : b;
  endfunction : upcase

  function automatic logic is_digit(input logic [7:0] b);
    is_digit = (b >= `CH_D0) && (b <= `CH_D9);
  endfunction : is_digit

  function automatic logic is_letter(input logic [7:0] b);
    is_letter = (b >= `CH_UC_A) && (b <= `CH_UC_Z);
  endfunction : is_letter

  function automatic logic is_delim(input logic [7:0] b);
    is_delim = (b == `CH_SP) || (b == `CH_SEMI) || (b == `CH_CR);
  endfunction : is_delim

  function automatic key_t mk_key(input key_kind_t kind, input logic [15:0] code);
    mk_key = '{remote: 1'b1, kind: kind, code: code};
  endfunction : mk_key

  function automatic logic addr_in_range(input logic [4:0] a);
    addr_in_range = (a >= `ADDR_MIN) && (a <= `ADDR_MAX);
  endfunction : addr_in_range

  always_comb begin
    c = upcase(s_r.replay ? s_r.held : rx_byte);
    take = s_r.replay || (rx_valid && s_r.rx_rdy);
    s_nxt = s_r;
    s_nxt.key_valid = 1'b0;
    s_nxt.syn_err = 1'b0;
    s_nxt.dev_clear = 1'b0;
    s_nxt.trig = 1'b0;
    s_nxt.replay = 1'b0;
    if (take) begin
      case (s_r.st)
        PS_IDLE: begin
          if (is_digit(c) || c == `CH_PERIOD) begin
            s_nxt.key_valid = 1'b1;
            s_nxt.key = mk_key(is_digit(c) ? KEY_DIGIT : KEY_PERIOD, {8'h00, c});
            s_nxt.num_open = 1'b1;
            s_nxt.num_closed = 1'b0;
            s_nxt.sp_seen = 1'b0;
          end else if (c == `CH_CR) begin
            s_nxt.sp_seen = 1'b0;
            if (s_r.num_closed) begin
              s_nxt.key_valid = 1'b1;
              s_nxt.key = mk_key(KEY_ENTER, {8'h00, `CH_UC_E});
              s_nxt.num_closed = 1'b0;
            end else if (s_r.num_open) begin
              s_nxt.num_open = 1'b0;
              s_nxt.num_closed = 1'b1;
            end
          end else if (c == `CH_SP) begin
            if (s_r.sp_seen) begin
              s_nxt.syn_err = 1'b1;
              s_nxt.st = PS_SKIP;
            end else begin
              s_nxt.sp_seen = 1'b1;
            end
          end else if (c == `CH_SEMI) begin
            s_nxt.sp_seen = 1'b0;
          end else if (is_letter(c)) begin
            s_nxt.num_open = 1'b0;
            s_nxt.num_closed = 1'b0;
            s_nxt.sp_seen = 1'b0;
            s_nxt.m1 = c;
            s_nxt.st = (c == `CH_UC_C) ? PS_CLR : PS_M1;
          end else begin
            s_nxt.syn_err = 1'b1;
            s_nxt.st = PS_SKIP;
          end
        end
        PS_CLR: begin
          if (is_letter(c)) begin
            s_nxt.m2 = c;
            s_nxt.st = PS_M2;
          end else begin
            s_nxt.key_valid = 1'b1;
            s_nxt.key = mk_key(KEY_CLEAR, {8'h00, `CH_UC_C});
            s_nxt.st = PS_IDLE;
            if (!is_delim(c)) begin
              s_nxt.held = c;
              s_nxt.replay = 1'b1;
            end
          end
        end
        PS_M1: begin
          if (is_letter(c) || is_digit(c)) begin
            s_nxt.m2 = c;
            s_nxt.st = PS_M2;
          end else if (is_delim(c)) begin
            s_nxt.key_valid = 1'b1;
            s_nxt.st = PS_IDLE;
            if (s_r.m1 == `CH_UC_E) begin
              s_nxt.key = mk_key(KEY_ENTER, {8'h00, `CH_UC_E});
            end else begin
              s_nxt.key = mk_key(KEY_MNEM, {s_r.m1, 8'h00});
            end
          end else begin
            s_nxt.syn_err = 1'b1;
            s_nxt.st = PS_SKIP;
          end
        end
        PS_M2: begin
          if (is_delim(c)) begin
            s_nxt.key_valid = 1'b1;
            s_nxt.key = mk_key(KEY_MNEM, {s_r.m1, s_r.m2});
            s_nxt.st = PS_IDLE;
          end else begin
            s_nxt.syn_err = 1'b1;
            s_nxt.st = PS_SKIP;
          end
        end
        PS_SKIP: begin
          if (c == `CH_CR) begin
            s_nxt.st = PS_IDLE;
          end
        end
        default: begin
          s_nxt.st = PS_IDLE;
        end
      endcase
    end else if (panel_valid && s_r.st == PS_IDLE && !s_r.lockout) begin
      s_nxt.key_valid = 1'b1;
      s_nxt.key = panel_key;
      s_nxt.key.remote = 1'b0;
    end
    s_nxt.addr_ok = addr_in_range(cfg_addr);
    if (bus_addr_stb) begin
      s_nxt.listen = s_r.addr_ok && (bus_addr == cfg_addr);
      if (s_nxt.listen) s_nxt.remote = 1'b1;
    end
    if (bus_evt.llo) s_nxt.lockout = 1'b1;
    if (bus_evt.gtl) begin
      s_nxt.lockout = 1'b0;
      s_nxt.remote = 1'b0;
    end
    if (bus_evt.get) s_nxt.trig = prog_wait_trig;
    if (bus_evt.ifc) begin
      s_nxt.st = PS_IDLE;
      s_nxt.replay = 1'b0;
      s_nxt.num_open = 1'b0;
      s_nxt.num_closed = 1'b0;
      s_nxt.sp_seen = 1'b0;
      s_nxt.listen = 1'b0;
    end
    if (bus_evt.dcl) begin
      s_nxt = '0;
      s_nxt.dev_clear = 1'b1;
      s_nxt.addr_ok = addr_in_range(cfg_addr);
    end
    s_nxt.rx_rdy = s_nxt.listen && !s_nxt.replay;
  end

  always_ff @(posedge core_clk) begin
    if (rst) s_r <= '0;
    else s_r <= s_nxt;
  end

  assign err_all = '{crc: instr_err.crc, unavail: instr_err.unavail,
                     syntax: instr_err.syntax | s_r.syn_err};

  sp_status u_status (
    .core_clk    (core_clk),
    .rst         (rst),
    .clr         (bus_evt.dcl),
    .err_in      (err_all),
    .spoll_rd    (bus_evt.spoll),
    .status_byte (status_byte),
    .srq         (srq)
  );

  term_attr_tx u_attr (
    .core_clk     (core_clk),
    .rst          (rst),
    .abort        (bus_evt.ifc | bus_evt.dcl),
    .ansi_mode    (ansi_mode),
    .home_row_bcd (home_row_bcd),
    .home_col_bcd (home_col_bcd),
    .req          (attr_req),
    .op           (attr_op),
    .req_ready    (attr_ready),
    .tx_ready     (tx_ready),
    .tx_valid     (tx_valid),
    .tx_byte      (tx_byte)
  );

  assign rx_ready = s_r.rx_rdy;
  assign key_valid = s_r.key_valid;
  assign key_out = s_r.key;
  assign addr_ok = s_r.addr_ok;
  assign listening = s_r.listen;
  assign remote = s_r.remote;
  assign lockout = s_r.lockout;
  assign dev_clear = s_r.dev_clear;
  assign trig_resume = s_r.trig;

  property p_addr_range;
    @(posedge core_clk) disable iff (rst)
      listening |-> addr_ok && (cfg_addr != 5'h00) && (cfg_addr <= `ADDR_MAX);
  endproperty
  a_addr_range: assert property (p_addr_range) else $error("listening on bad address");

  property p_panel_locked;
    @(posedge core_clk) disable iff (rst)
      key_valid && !key_out.remote |-> !$past(lockout);
  endproperty
  a_panel_locked: assert property (p_panel_locked) else $error("panel key under lockout");

  property p_bad_char;
    @(posedge core_clk) disable iff (rst)
      rx_valid && rx_ready && s_r.st == PS_IDLE && !s_r.replay && rx_byte == 8'h21
      && !bus_evt.dcl && !bus_evt.ifc
      |=> ##1 (status_byte[`SPB_SYNTAX] || $past(bus_evt.dcl));
  endproperty
  a_bad_char: assert property (p_bad_char) else $error("syntax error not flagged");

  property p_err_srq;
    @(posedge core_clk) disable iff (rst)
      (|instr_err) && !bus_evt.dcl |=> srq && status_byte[`SPB_RQS];
  endproperty
  a_err_srq: assert property (p_err_srq) else $error("error raised no service request");

  property p_poll_clears;
    @(posedge core_clk) disable iff (rst)
      bus_evt.spoll && !(|err_all) |=> !srq;
  endproperty
  a_poll_clears: assert property (p_poll_clears) else $error("poll left request set");

  property p_err_hold;
    @(posedge core_clk) disable iff (rst)
      !(|err_all) && !bus_evt.dcl |=> $stable(status_byte[2:0]);
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error bits changed without error");

  property p_err_onehot;
    @(posedge core_clk) disable iff (rst)
      (|err_all) && !bus_evt.dcl |=> $onehot(status_byte[2:0]);
  endproperty
  a_err_onehot: assert property (p_err_onehot) else $error("error bits not rewritten");

  property p_get_resume;
    @(posedge core_clk) disable iff (rst)
      bus_evt.get && prog_wait_trig && !bus_evt.dcl |=> trig_resume ##1 !trig_resume;
  endproperty
  a_get_resume: assert property (p_get_resume) else $error("trigger did not resume");

  property p_dcl;
    @(posedge core_clk) disable iff (rst)
      bus_evt.dcl |=> dev_clear && !lockout && !listening && !remote && !srq;
  endproperty
  a_dcl: assert property (p_dcl) else $error("device clear incomplete");

  property p_ifc;
    @(posedge core_clk) disable iff (rst)
      bus_evt.ifc |=> !rx_ready && !listening && !tx_valid;
  endproperty
  a_ifc: assert property (p_ifc) else $error("interface clear did not abort");

  property p_llo;
    @(posedge core_clk) disable iff (rst)
      bus_evt.llo && !bus_evt.gtl && !bus_evt.dcl |=> lockout;
  endproperty
  a_llo: assert property (p_llo) else $error("lockout not entered");

  property p_gtl;
    @(posedge core_clk) disable iff (rst)
      bus_evt.gtl |=> !lockout && !remote;
  endproperty
  a_gtl: assert property (p_gtl) else $error("return to local ignored");

  // A panel key is taken when the parser is idle, lockout is off and no byte arrives
  property p_panel_key;
    @(posedge core_clk) disable iff (rst)
      panel_valid && !lockout && s_r.st == PS_IDLE && !s_r.replay
      && !(rx_valid && rx_ready) && !bus_evt.dcl |=> key_valid && !key_out.remote;
  endproperty
  a_panel_key: assert property (p_panel_key) else $error("panel key not accepted");
endmodule : ieee488_remote_command_port

// ### verilog/rcp_consts.svh
// Character codes, status-byte layout and address limits of the remote command port
`ifndef RCP_CONSTS_SVH
`define RCP_CONSTS_SVH
`define CH_CR       8'h0d
`define CH_ESC      8'h1b
`define CH_SP       8'h20
`define CH_PERIOD   8'h2e
`define CH_D0       8'h30
`define CH_D9       8'h39
`define CH_SEMI     8'h3b
`define CH_UC_A     8'h41
`define CH_UC_C     8'h43
`define CH_UC_E     8'h45
`define CH_UC_H     8'h48
`define CH_UC_Z     8'h5a
`define CH_LBRACK   8'h5b
`define CH_LC_A     8'h61
`define CH_LC_M     8'h6d
`define CH_LC_Z     8'h7a
`define CH_LBRACE   8'h7b
`define CH_RBRACE   8'h7d
`define CH_CASE_OFS 8'h20
`define CH_SGR_HL   8'h37
`define CH_SGR_BL   8'h35
`define CH_SGR_OFF  8'h30
`define SPB_SYNTAX  0
`define SPB_CRC     2
`define SPB_RQS     6
`define ADDR_MIN    5'h01
`define ADDR_MAX    5'h1e
`endif

// ### verilog/rcp_pkg.sv
// Types shared by the remote command port modules
package rcp_pkg;
  typedef enum logic [2:0] {
    KEY_DIGIT  = 3'b000,
    KEY_PERIOD = 3'b001,
    KEY_CLEAR  = 3'b010,
    KEY_ENTER  = 3'b011,
    KEY_MNEM   = 3'b100
  } key_kind_t;
  typedef struct packed {
    logic      remote;
    key_kind_t kind;
    logic [15:0] code;
  } key_t;
  typedef struct packed {
    logic crc;
    logic unavail;
    logic syntax;
  } err_t;
  typedef struct packed {
    logic ifc;
    logic dcl;
    logic get;
    logic llo;
    logic gtl;
    logic spoll;
  } bus_evt_t;
  typedef enum logic [1:0] {
    ATTR_HL_ON    = 2'b00,
    ATTR_BLINK_ON = 2'b01,
    ATTR_OFF      = 2'b10,
    ATTR_HOME     = 2'b11
  } attr_op_t;
  typedef enum logic [2:0] {
    PS_IDLE = 3'b000,
    PS_CLR  = 3'b001,
    PS_M1   = 3'b010,
    PS_M2   = 3'b011,
    PS_SKIP = 3'b100
  } parse_st_t;
  typedef struct packed {logic [2:0] err; logic rqs;} spoll_st_t;
  typedef struct packed {
    logic busy; logic ansi; attr_op_t op; logic [3:0] idx;
    logic rdy; logic tx_valid; logic [7:0] tx_byte;
  } attr_st_t;
  typedef struct packed {
    parse_st_t st; logic [7:0] m1; logic [7:0] m2; logic [7:0] held;
    logic replay; logic num_open; logic num_closed; logic sp_seen;
    logic listen; logic remote; logic lockout; logic addr_ok; logic rx_rdy;
    logic key_valid; key_t key; logic syn_err; logic dev_clear; logic trig;
  } top_st_t;
endpackage : rcp_pkg

// ### verilog/sp_status.sv
// Serial-poll status byte with request-service flag and latest-error bits
`include "rcp_consts.svh"
module sp_status
  import rcp_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       clr,
  input  wire err_t       err_in,
  input  wire logic       spoll_rd,
  output logic      [7:0] status_byte,
  output logic            srq
);
  spoll_st_t s_r;
  spoll_st_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (spoll_rd) begin
      s_nxt.rqs = 1'b0;
    end
    if (|err_in) begin
      s_nxt.rqs = 1'b1;
      if (err_in.syntax) s_nxt.err = 3'b001;
      else if (err_in.unavail) s_nxt.err = 3'b010;
      else s_nxt.err = 3'b100;
    end
    if (clr) begin
      s_nxt = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) s_r <= '0;
    else s_r <= s_nxt;
  end

  always_comb begin
    status_byte = 8'h00;
    status_byte[`SPB_RQS] = s_r.rqs;
    status_byte[`SPB_CRC:`SPB_SYNTAX] = s_r.err;
  end
  assign srq = s_r.rqs;
endmodule : sp_status

// ### verilog/term_attr_tx.sv
// Screen attribute encoder: escape sequences or brace markers toward the controller
`include "rcp_consts.svh"
module term_attr_tx
  import rcp_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       abort,
  input  wire logic       ansi_mode,
  input  wire logic [7:0] home_row_bcd,
  input  wire logic [7:0] home_col_bcd,
  input  wire logic       req,
  input  wire attr_op_t   op,
  output logic            req_ready,
  input  wire logic       tx_ready,
  output logic            tx_valid,
  output logic      [7:0] tx_byte
);
  localparam attr_st_t ATTR_RST = '{rdy: 1'b1, op: ATTR_HL_ON, default: '0};
  attr_st_t s_r;
  attr_st_t s_nxt;

  // Returns {last, byte} for one step of the sequence
  function automatic logic [8:0] seq_char(input attr_st_t st, input logic [7:0] row,
                                          input logic [7:0] col);
    logic [7:0] c;
    logic       last;
    c = `CH_ESC;
    last = 1'b0;
    if (!st.ansi) begin
      c = (st.op == ATTR_OFF) ? `CH_RBRACE : `CH_LBRACE;
      last = 1'b1;
    end else begin
      case (st.idx)
        4'h1: c = `CH_LBRACK;
        4'h2: c = (st.op == ATTR_HOME) ? {4'h3, row[7:4]} :
                  (st.op == ATTR_HL_ON) ? `CH_SGR_HL :
                  (st.op == ATTR_BLINK_ON) ? `CH_SGR_BL : `CH_SGR_OFF;
        4'h3: begin
          c = (st.op == ATTR_HOME) ? {4'h3, row[3:0]} : `CH_LC_M;
          last = (st.op != ATTR_HOME);
        end
        4'h4: c = `CH_SEMI;
        4'h5: c = {4'h3, col[7:4]};
        4'h6: c = {4'h3, col[3:0]};
        4'h7: begin
          c = `CH_UC_H;
          last = 1'b1;
        end
        default: c = `CH_ESC;
      endcase
    end
    seq_char = {last, c};
  endfunction : seq_char

  always_comb begin
    logic [8:0] sc;
    sc = seq_char(s_r, home_row_bcd, home_col_bcd);
    s_nxt = s_r;
    if (s_r.tx_valid && tx_ready) s_nxt.tx_valid = 1'b0;
    if (s_r.busy && (!s_r.tx_valid || tx_ready)) begin
      s_nxt.tx_valid = 1'b1;
      s_nxt.tx_byte = sc[7:0];
      s_nxt.idx = s_r.idx + 4'h1;
      s_nxt.busy = !sc[8];
    end else if (s_r.rdy && req) begin
      s_nxt.op = op;
      s_nxt.ansi = ansi_mode;
      s_nxt.idx = 4'h0;
      s_nxt.busy = ansi_mode || (op != ATTR_HOME);
    end
    s_nxt.rdy = !s_nxt.busy;
    if (abort) s_nxt = ATTR_RST;
  end

  always_ff @(posedge core_clk) begin
    if (rst) s_r <= ATTR_RST;
    else s_r <= s_nxt;
  end

  assign req_ready = s_r.rdy;
  assign tx_valid = s_r.tx_valid;
  assign tx_byte = s_r.tx_byte;

  property p_tx_hold;
    @(posedge core_clk) disable iff (rst)
      tx_valid && !tx_ready && !abort |=> tx_valid && $stable(tx_byte);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx byte dropped before taken");
endmodule : term_attr_tx

// ### sim/bus_ctrl_model.sv
// Bus controller model: sends command bytes, takes screen bytes
module bus_ctrl_model
  import rcp_pkg::*;
(
  input  wire logic       core_clk,
  output logic            rx_valid,
  output logic      [7:0] rx_byte,
  input  wire logic       rx_ready,
  output logic            tx_ready,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_byte
);
  timeunit 1ns;
  timeprecision 1ps;

  logic       stall;
  logic [7:0] txq[$];
  int         hang;

  initial begin
    rx_valid = 1'b0;
    rx_byte  = 8'h00;
    tx_ready = 1'b1;
    stall    = 1'b0;
    hang     = 0;
  end

  // Slow mode takes a screen byte only every other cycle
  always @(posedge core_clk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) txq.push_back(tx_byte);
    tx_ready <= #1 stall ? ~tx_ready : 1'b1;
  end

  // Bytes go back to back; released data lines show a changed value
  task automatic send(input string s);
    int n;
    @(posedge core_clk);
    for (int i = 0; i < s.len(); i++) begin
      #1;
      rx_valid = 1'b1;
      rx_byte  = s[i];
      n = 0;
      do begin
        @(posedge core_clk);
        n++;
      end while (rx_ready !== 1'b1 && n < 50);
      if (rx_ready !== 1'b1) hang++;
    end
    #1;
    rx_valid = 1'b0;
    rx_byte  = ~rx_byte;
  endtask : send

  // Error bits count only when the request flag is set
  function automatic logic [2:0] poll_errs(input logic [7:0] sb);
    return sb[6] ? sb[2:0] : 3'h0;
  endfunction : poll_errs
endmodule : bus_ctrl_model

// ### sim/tb_ieee488_remote_command_port.sv
// Self-checking bench for the remote command port
module tb_ieee488_remote_command_port
  import rcp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic core_clk, rst, bus_addr_stb, rx_valid, rx_ready, panel_valid, prog_wait_trig;
  logic attr_req, attr_ready, tx_ready, tx_valid, key_valid, addr_ok, listening;
  logic remote, lockout, srq, dev_clear, trig_resume, ansi_mode;
  logic [4:0] cfg_addr, bus_addr;
  logic [7:0] home_row_bcd, home_col_bcd, rx_byte, tx_byte, status_byte;
  bus_evt_t   bus_evt;
  key_t       panel_key, key_out;
  err_t       instr_err;
  attr_op_t   attr_op;
  key_t       keys[$];
  int         miscompares = 0;
  int         total_checks = 0;
  logic [7:0] exp_tx[14] = '{8'h1b, 8'h5b, 8'h31, 8'h32, 8'h3b, 8'h33, 8'h34, 8'h48,
                             8'h1b, 8'h5b, 8'h35, 8'h6d, 8'h7b, 8'h7d};

  ieee488_remote_command_port i_ieee488_remote_command_port (.core_clk(core_clk), .rst(rst),
    .cfg_addr(cfg_addr), .ansi_mode(ansi_mode), .home_row_bcd(home_row_bcd),
    .home_col_bcd(home_col_bcd), .bus_addr_stb(bus_addr_stb), .bus_addr(bus_addr),
    .bus_evt(bus_evt), .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_ready(rx_ready),
    .panel_valid(panel_valid), .panel_key(panel_key), .prog_wait_trig(prog_wait_trig),
    .instr_err(instr_err), .attr_req(attr_req), .attr_op(attr_op), .attr_ready(attr_ready),
    .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_byte(tx_byte), .key_valid(key_valid),
    .key_out(key_out), .addr_ok(addr_ok), .listening(listening), .remote(remote),
    .lockout(lockout), .status_byte(status_byte), .srq(srq), .dev_clear(dev_clear),
    .trig_resume(trig_resume));

  bus_ctrl_model i_bus_ctrl_model (.core_clk(core_clk), .rx_valid(rx_valid),
    .rx_byte(rx_byte), .rx_ready(rx_ready), .tx_ready(tx_ready), .tx_valid(tx_valid),
    .tx_byte(tx_byte));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  always @(posedge core_clk) if (key_valid === 1'b1) keys.push_back(key_out);

  task automatic give_verdict();
    if (miscompares == 0 && total_checks > 0 && i_bus_ctrl_model.hang == 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict

  task automatic chk_val(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_val

  task automatic chk_key(input logic r, input key_kind_t k, input logic [15:0] c);
    key_t got;
    got = (keys.size() > 0) ? keys.pop_front() : 'x;
    total_checks++;
    if (got !== {r, k, c}) begin
      miscompares++;
      $display("CHECK FAILED key expected %h seen %h", {r, k, c}, got);
    end
  endtask : chk_key

  // A byte not taken within 50 cycles ends the run once the whole string has been sent
  task automatic send_chk(input string s);
    i_bus_ctrl_model.send(s);
    if (i_bus_ctrl_model.hang != 0) begin
      miscompares++;
      give_verdict();
    end
  endtask : send_chk

  task automatic evt(input bus_evt_t e);
    @(posedge core_clk);
    #1 bus_evt = e;
    @(posedge core_clk);
    #1 bus_evt = '0;
  endtask : evt

  task automatic addr(input logic [4:0] a);
    @(posedge core_clk);
    #1 bus_addr_stb = 1'b1;
    bus_addr = a;
    @(posedge core_clk);
    #1 bus_addr_stb = 1'b0;
  endtask : addr

  task automatic pulse_in(input err_t e, input logic pv);
    @(posedge core_clk);
    #1 instr_err = e;
    panel_valid = pv;
    @(posedge core_clk);
    #1 instr_err = '0;
    panel_valid = 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
  endtask : pulse_in

  task automatic attr(input attr_op_t o, input bit fin);
    int n;
    @(posedge core_clk);
    #1 attr_req = 1'b1;
    attr_op = o;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (attr_ready !== 1'b1 && n < 50);
    #1 attr_req = 1'b0;
    while (fin && attr_ready !== 1'b1 && n < 50) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 50) begin
      miscompares++;
      give_verdict();
    end
    if (fin) begin
      repeat (5) @(posedge core_clk);
      #1;
    end
  endtask : attr

  initial begin
    {rst, bus_addr_stb, panel_valid, prog_wait_trig, attr_req, ansi_mode} = 6'h3f;
    {bus_addr_stb, panel_valid, prog_wait_trig, attr_req, ansi_mode} = '0;
    {bus_evt, instr_err, attr_op, bus_addr} = '0;
    cfg_addr = 5'h05;
    home_row_bcd = 8'h12;
    home_col_bcd = 8'h34;
    panel_key = {1'b1, KEY_DIGIT, 16'h0037};
    repeat (16) @(posedge core_clk);
    #1 rst = 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    chk_val("status", 8'h00, status_byte);
    chk_val("attr_ready", 8'h01, {7'h0, attr_ready});
    chk_val("addr_ok", 8'h01, {7'h0, addr_ok});
    addr(5'h00);
    chk_val("listen", 8'h00, {7'h0, listening});
    addr(5'h05);
    chk_val("listen", 8'h01, {7'h0, listening});
    chk_val("remote", 8'h01, {7'h0, remote});
    chk_val("rx_ready", 8'h01, {7'h0, rx_ready});
    send_chk("f1\015F1\015 12\015\015mn;e\015c5\015");
    repeat (4) @(posedge core_clk);
    chk_key(1'b1, KEY_MNEM, 16'h4631);
    chk_key(1'b1, KEY_MNEM, 16'h4631);
    chk_key(1'b1, KEY_DIGIT, 16'h0031);
    chk_key(1'b1, KEY_DIGIT, 16'h0032);
    chk_key(1'b1, KEY_ENTER, 16'h0045);
    chk_key(1'b1, KEY_MNEM, 16'h4d4e);
    chk_key(1'b1, KEY_ENTER, 16'h0045);
    chk_key(1'b1, KEY_CLEAR, 16'h0043);
    chk_key(1'b1, KEY_DIGIT, 16'h0035);
    chk_val("extra keys", 8'h00, 8'(keys.size()));
    send_chk("fxy\015!\015");
    repeat (3) @(posedge core_clk);
    #1;
    chk_val("status", 8'h41, status_byte);
    chk_val("poll errs", 8'h01, {5'h0, i_bus_ctrl_model.poll_errs(status_byte)});
    chk_val("srq", 8'h01, {7'h0, srq});
    evt(6'h01);
    chk_val("status", 8'h01, status_byte);
    chk_val("poll errs", 8'h00, {5'h0, i_bus_ctrl_model.poll_errs(status_byte)});
    evt(6'h01);
    chk_val("status", 8'h01, status_byte);
    pulse_in(3'b010, 1'b0);
    chk_val("status", 8'h42, status_byte);
    pulse_in(3'b100, 1'b0);
    chk_val("status", 8'h44, status_byte);
    evt(6'h04);
    chk_val("lockout", 8'h01, {7'h0, lockout});
    pulse_in('0, 1'b1);
    chk_val("locked keys", 8'h00, 8'(keys.size()));
    evt(6'h02);
    chk_val("remote", 8'h00, {7'h0, remote});
    pulse_in('0, 1'b1);
    chk_key(1'b0, KEY_DIGIT, 16'h0037);
    evt(6'h08);
    chk_val("resume", 8'h00, {7'h0, trig_resume});
    prog_wait_trig = 1'b1;
    evt(6'h08);
    chk_val("resume", 8'h01, {7'h0, trig_resume});
    ansi_mode = 1'b1;
    i_bus_ctrl_model.stall = 1'b1;
    attr(ATTR_HOME, 1'b1);
    attr(ATTR_BLINK_ON, 1'b1);
    ansi_mode = 1'b0;
    attr(ATTR_HL_ON, 1'b1);
    attr(ATTR_OFF, 1'b1);
    attr(ATTR_HOME, 1'b1);
    chk_val("tx count", 8'd14, 8'(i_bus_ctrl_model.txq.size()));
    for (int i = 0; i < 14; i++)
      chk_val("tx byte", exp_tx[i], i_bus_ctrl_model.txq.pop_front());
    ansi_mode = 1'b1;
    attr(ATTR_HL_ON, 1'b0);
    evt(6'h20);
    repeat (8) @(posedge core_clk);
    chk_val("aborted tx", 8'h01, 8'(i_bus_ctrl_model.txq.size() < 4));
    chk_val("listen", 8'h00, {7'h0, listening});
    chk_val("rx_ready", 8'h00, {7'h0, rx_ready});
    addr(5'h05);
    evt(6'h10);
    chk_val("dev_clear", 8'h01, {7'h0, dev_clear});
    chk_val("status", 8'h00, status_byte);
    chk_val("listen", 8'h00, {7'h0, listening});
    cfg_addr = 5'h1f;
    addr(5'h1f);
    chk_val("addr_ok", 8'h00, {7'h0, addr_ok});
    chk_val("listen", 8'h00, {7'h0, listening});
    give_verdict();
  end
endmodule : tb_ieee488_remote_command_port
